// ---- design/hscc_pkg.sv ----
package hscc_pkg;
    // Register offsets
    localparam logic [7:0] OFS_DEVICE_MODE_CONTROL = 8'h01;
    localparam logic [7:0] OFS_CHANNEL_AND_SLEEP = 8'h02;
    localparam logic [7:0] OFS_THRESHOLD_ANGLE_RANGE = 8'h03;
    localparam logic [7:0] OFS_THR_X = 8'h04;
    localparam logic [7:0] OFS_THR_Y = 8'h05;
    localparam logic [7:0] OFS_THR_Z = 8'h06;
    localparam logic [7:0] REG_RESET = 8'h00;
    // Field positions
    localparam int STYLE_HI = 7;
    localparam int STYLE_LO = 5;
    localparam int NOISE_BIT = 4;
    localparam int GLITCH_BIT = 3;
    localparam int TRIG_SRC_BIT = 2;
    localparam int CHAN_HI = 7;
    localparam int CHAN_LO = 4;
    localparam int CROSS_BIT = 6;
    localparam int DIR_BIT = 5;
    localparam int GAIN_BIT = 4;
    localparam int ANGLE_HI = 3;
    localparam int ANGLE_LO = 2;
    localparam int XY_RANGE_BIT = 1;
    localparam int Z_RANGE_BIT = 0;
    localparam logic [7:0] RANGE_WR_MASK = 8'h7F;
    // Field codes
    localparam logic [2:0] STYLE_SIGNED = 3'h0;
    localparam logic [2:0] STYLE_SYMMETRIC = 3'h1;
    localparam logic [2:0] CROSS_ONE = 3'h1;
    localparam logic [2:0] CROSS_FOUR = 3'h4;
    typedef enum logic [1:0]
    {
        MODE_STANDBY = 2'h0,
        MODE_SLEEP = 2'h1,
        MODE_CONTINUOUS = 2'h2,
        MODE_WAKE_SLEEP = 2'h3
    } hscc_mode_type;
    // Timing
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned NS_PER_MS = 1000000;
    localparam int unsigned CONV_TIME_NS = 10000;
    localparam int unsigned CONV_CYCLES =
        (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CYCLES_PER_MS_DEFAULT = NS_PER_MS / CLK_PERIOD_NS;
    localparam int SLEEP_CODES = 13;
    localparam logic [3:0] SLEEP_LAST = 4'hC;
    localparam int unsigned SLEEP_MS [SLEEP_CODES] =
        '{1, 5, 10, 15, 20, 30, 50, 100, 500, 1000, 2000, 5000, 20000};
endpackage

// ---- design/hscc_config.sv ----
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Style bits 7-5: 0 signed limits, 1 symmetric seven-bit limits.
// - Mode register bit 4: 0 low current, 1 low noise.
// - Mode register bit 3: 0 glitch filter on, 1 bypassed.
// - Mode register bit 2: 0 command trigger, 1 interrupt-pin trigger.
// - Trigger in conversion waits its end; extra triggers are dropped.
// - Trigger source matters only in standby mode.
// - Mode bits 1-0: standby, sleep, continuous, wake-up-and-sleep.
// - Falling back from wake-sleep to standby rewrites the mode field.
// - Channel bits 7-4 pick axes and sequences; higher codes reserved.
// - Sleep bits 3-0 set wake-sleep interval, 1 ms to 20000 ms.
// - Range register bit 6: one or four crossings before threshold event.
// - Bit 5 picks above or below; ignored when style exceeds 1.
// - Bit 4 picks first or second angle channel for gain correction.
// - Bits 3-2 enable angle calculation and choose its axis pair.
// - Bit 1 doubles the X and Y full-scale range.
// - Bit 0 doubles the Z full-scale range independently.
// - Mode register resets to zero.
// - Zero threshold code disables comparison on that axis.
module hscc_config
#(
    parameter int unsigned CYCLES_PER_MS = hscc_pkg::CYCLES_PER_MS_DEFAULT
)
(
    // Clocks and reset
    input wire logic ref_clk,
    input wire logic link_clk,
    input wire logic rst,
    // Register link, link_clk domain
    input wire logic link_sel,
    input wire logic link_write,
    input wire logic [7:0] link_addr,
    input wire logic [7:0] link_wdata,
    input wire logic link_trig_cmd,
    output logic [7:0] link_rdata,
    output logic link_busy,
    // Interrupt pin used as trigger, asynchronous, active low
    input wire logic int_trig_n,
    // Configuration outputs
    output logic [2:0] threshold_style_select,
    output logic noise_power_select,
    output logic glitch_filter_en,
    output logic trig_from_pin,
    output logic [1:0] operating_mode,
    output logic [3:0] axis_channel_enable,
    output logic [3:0] sleep_interval_select,
    output logic [2:0] crossings_needed,
    output logic threshold_direction,
    output logic gain_channel_select,
    output logic [1:0] angle_pair_select,
    output logic xy_range_double,
    output logic z_range_double,
    output logic [7:0] axis_threshold_code_x,
    output logic [7:0] axis_threshold_code_y,
    output logic [7:0] axis_threshold_code_z,
    output logic [2:0] axis_threshold_enable,
    // Sequencer status
    output logic conv_start,
    output logic conv_active
);
    import hscc_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_CONVERT, ST_SLEEPING}
        hscc_state_type;

    typedef struct packed
    {
        logic req_tgl;
        logic write;
        logic trig;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic busy;
        logic [2:0] ack_sync;
    } hscc_link_type;

    typedef struct packed
    {
        logic [7:0] mode_ctl;
        logic [7:0] chan_sleep;
        logic [7:0] range_sel;
        logic [7:0] thr_x;
        logic [7:0] thr_y;
        logic [7:0] thr_z;
        hscc_state_type st;
        logic [31:0] cnt;
        logic pend;
        logic start;
        logic [7:0] rdata;
        logic ack_tgl;
        logic [2:0] req_sync;
        logic [2:0] pin_sync;
    } hscc_core_type;

    hscc_link_type lk_reg;
    hscc_link_type lk_next;
    hscc_core_type cr_reg;
    hscc_core_type cr_next;

    logic ack_edge;
    logic req_edge;
    logic pin_fall;
    logic cmd_trig;
    logic trig_ev;
    logic wr_hit;
    logic [1:0] mode;
    logic [3:0] sleep_idx;
    logic [31:0] sleep_cycles;

    // Link side: one transfer in flight; new ones are dropped while busy
    assign ack_edge = lk_reg.ack_sync[1] ^ lk_reg.ack_sync[2];

    always_comb
    begin
        lk_next = lk_reg;
        lk_next.ack_sync = {lk_reg.ack_sync[1:0], cr_reg.ack_tgl};
        if (ack_edge)
        begin
            lk_next.busy = 1'b0;
            lk_next.rdata = cr_reg.rdata;
        end
        if (link_sel && !lk_reg.busy)
        begin
            lk_next.busy = 1'b1;
            lk_next.req_tgl = ~lk_reg.req_tgl;
            lk_next.write = link_write;
            lk_next.trig = link_trig_cmd;
            lk_next.addr = link_addr;
            lk_next.wdata = link_wdata;
        end
    end

    always_ff @(posedge link_clk or posedge rst)
    begin
        if (rst)
            lk_reg <= '0;
        else
            lk_reg <= lk_next;
    end

    assign link_rdata = lk_reg.rdata;
    assign link_busy = lk_reg.busy;

    // Core side; link fields are stable while the request toggle is open
    assign req_edge = cr_reg.req_sync[1] ^ cr_reg.req_sync[2];
    assign pin_fall = cr_reg.pin_sync[2] & ~cr_reg.pin_sync[1];
    assign cmd_trig = req_edge & lk_reg.trig;
    assign wr_hit = req_edge & lk_reg.write &
        (lk_reg.addr == OFS_DEVICE_MODE_CONTROL);
    assign mode = cr_reg.mode_ctl[1:0];
    // Source is chosen by bit 2 and honoured only in standby
    assign trig_ev = (mode == MODE_STANDBY) &&
        (cr_reg.mode_ctl[TRIG_SRC_BIT] ? pin_fall : cmd_trig);
    // Reserved codes clamp to the longest interval
    assign sleep_idx = (cr_reg.chan_sleep[3:0] > SLEEP_LAST) ? SLEEP_LAST :
        cr_reg.chan_sleep[3:0];
    assign sleep_cycles =
        32'(SLEEP_MS[sleep_idx] * CYCLES_PER_MS);

    always_comb
    begin
        cr_next = cr_reg;
        cr_next.req_sync = {cr_reg.req_sync[1:0], lk_reg.req_tgl};
        cr_next.pin_sync = {cr_reg.pin_sync[1:0], int_trig_n};
        cr_next.start = 1'b0;
        case (cr_reg.st)
            ST_IDLE:
            begin
                if (mode == MODE_CONTINUOUS || mode == MODE_WAKE_SLEEP ||
                    trig_ev)
                begin
                    cr_next.st = ST_CONVERT;
                    cr_next.cnt = 32'(CONV_CYCLES - 1);
                    cr_next.start = 1'b1;
                end
            end
            ST_CONVERT:
            begin
                // One trigger may wait, even one in the last cycle
                if (trig_ev)
                    cr_next.pend = 1'b1;
                if (cr_reg.cnt != 32'h0)
                    cr_next.cnt = cr_reg.cnt - 32'h1;
                else if (mode == MODE_WAKE_SLEEP)
                begin
                    cr_next.st = ST_SLEEPING;
                    cr_next.cnt = sleep_cycles - 32'h1;
                end
                else if (mode == MODE_CONTINUOUS || (mode == MODE_STANDBY &&
                    (cr_reg.pend || trig_ev)))
                begin
                    cr_next.cnt = 32'(CONV_CYCLES - 1);
                    cr_next.start = 1'b1;
                    cr_next.pend = 1'b0;
                end
                else
                begin
                    cr_next.st = ST_IDLE;
                    cr_next.pend = 1'b0;
                end
            end
            ST_SLEEPING:
            begin
                if (mode != MODE_WAKE_SLEEP)
                    cr_next.st = ST_IDLE;
                else if (pin_fall)
                begin
                    // Pin wake ends cycling; field shows standby again
                    cr_next.mode_ctl[1:0] = MODE_STANDBY;
                    cr_next.st = ST_IDLE;
                end
                else if (cr_reg.cnt == 32'h0)
                begin
                    cr_next.st = ST_CONVERT;
                    cr_next.cnt = 32'(CONV_CYCLES - 1);
                    cr_next.start = 1'b1;
                end
                else
                    cr_next.cnt = cr_reg.cnt - 32'h1;
            end
            default:
                cr_next.st = ST_IDLE;
        endcase
        // Host access; a host write outranks the fallback in the same cycle
        if (req_edge)
        begin
            cr_next.ack_tgl = ~cr_reg.ack_tgl;
            case (lk_reg.addr)
                OFS_DEVICE_MODE_CONTROL: cr_next.rdata = cr_reg.mode_ctl;
                OFS_CHANNEL_AND_SLEEP: cr_next.rdata = cr_reg.chan_sleep;
                OFS_THRESHOLD_ANGLE_RANGE: cr_next.rdata = cr_reg.range_sel;
                OFS_THR_X: cr_next.rdata = cr_reg.thr_x;
                OFS_THR_Y: cr_next.rdata = cr_reg.thr_y;
                OFS_THR_Z: cr_next.rdata = cr_reg.thr_z;
                default: cr_next.rdata = 8'h00;
            endcase
            if (lk_reg.write)
            begin
                case (lk_reg.addr)
                    OFS_DEVICE_MODE_CONTROL: cr_next.mode_ctl = lk_reg.wdata;
                    OFS_CHANNEL_AND_SLEEP: cr_next.chan_sleep = lk_reg.wdata;
                    OFS_THRESHOLD_ANGLE_RANGE:
                        cr_next.range_sel = lk_reg.wdata & RANGE_WR_MASK;
                    OFS_THR_X: cr_next.thr_x = lk_reg.wdata;
                    OFS_THR_Y: cr_next.thr_y = lk_reg.wdata;
                    OFS_THR_Z: cr_next.thr_z = lk_reg.wdata;
                    default: cr_next.rdata = 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            cr_reg <= '0;
        else
            cr_reg <= cr_next;
    end

    // Field decode
    assign threshold_style_select =
        cr_reg.mode_ctl[STYLE_HI:STYLE_LO];
    assign noise_power_select = cr_reg.mode_ctl[NOISE_BIT];
    assign glitch_filter_en = ~cr_reg.mode_ctl[GLITCH_BIT];
    assign trig_from_pin = cr_reg.mode_ctl[TRIG_SRC_BIT];
    assign operating_mode = mode;
    assign axis_channel_enable =
        cr_reg.chan_sleep[CHAN_HI:CHAN_LO];
    assign sleep_interval_select = cr_reg.chan_sleep[3:0];
    assign crossings_needed = cr_reg.range_sel[CROSS_BIT] ? CROSS_FOUR :
        CROSS_ONE;
    // Direction only means something for the two defined styles
    assign threshold_direction = cr_reg.range_sel[DIR_BIT] &
        (threshold_style_select <= STYLE_SYMMETRIC);
    assign gain_channel_select = cr_reg.range_sel[GAIN_BIT];
    assign angle_pair_select =
        cr_reg.range_sel[ANGLE_HI:ANGLE_LO];
    assign xy_range_double = cr_reg.range_sel[XY_RANGE_BIT];
    assign z_range_double = cr_reg.range_sel[Z_RANGE_BIT];
    assign axis_threshold_code_x = cr_reg.thr_x;
    assign axis_threshold_code_y = cr_reg.thr_y;
    assign axis_threshold_code_z = cr_reg.thr_z;
    assign axis_threshold_enable = {cr_reg.thr_z != 8'h00,
        cr_reg.thr_y != 8'h00, cr_reg.thr_x != 8'h00};
    assign conv_start = cr_reg.start;
    assign conv_active = (cr_reg.st == ST_CONVERT);

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_conv_end;
        cr_reg.st == ST_CONVERT && cr_reg.cnt == 32'h0;
    endsequence

    sequence s_mode_write;
        req_edge && lk_reg.write && lk_reg.addr == OFS_DEVICE_MODE_CONTROL;
    endsequence

    a_mode_field_write: assert property (s_mode_write |=>
        cr_reg.mode_ctl[7:2] == $past(lk_reg.wdata[7:2]))
        else $error("mode register upper fields not written");
    a_dir_style_mask: assert property (
        threshold_style_select > STYLE_SYMMETRIC |-> !threshold_direction)
        else $error("direction not ignored for reserved style");
    a_cross_four: assert property (
        cr_reg.range_sel[CROSS_BIT] |-> crossings_needed == CROSS_FOUR)
        else $error("crossing count wrong");
    a_start_spacing: assert property (conv_start |->
        $past(cr_reg.st) != ST_CONVERT || $past(cr_reg.cnt) == 32'h0)
        else $error("conversion restarted before finishing");
    a_sleep_no_conv: assert property (
        cr_reg.st == ST_IDLE && mode == MODE_SLEEP |=> !conv_start)
        else $error("conversion started in sleep mode");
    a_wake_to_sleep: assert property (
        s_conv_end ##0 (mode == MODE_WAKE_SLEEP) |=>
        cr_reg.st == ST_SLEEPING && cr_reg.cnt == $past(sleep_cycles) - 32'h1)
        else $error("sleep interval not loaded");
    a_fallback_mode: assert property (
        cr_reg.st == ST_SLEEPING && mode == MODE_WAKE_SLEEP && pin_fall &&
        !wr_hit |=> mode == MODE_STANDBY && cr_reg.st == ST_IDLE)
        else $error("fallback did not update mode field");
    a_trig_pending: assert property (
        s_conv_end ##0 ((cr_reg.pend || trig_ev) && mode == MODE_STANDBY) |=>
        conv_start && conv_active && !cr_reg.pend)
        else $error("pending trigger lost");
    a_thr_disable: assert property (
        cr_reg.thr_x == 8'h00 |-> !axis_threshold_enable[0])
        else $error("zero threshold not disabled");
    a_reserved_bit: assert property (req_edge |=>
        cr_reg.range_sel[7] == 1'b0)
        else $error("reserved bit set");
endmodule
`default_nettype wire

// ---- test/hscc_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module hscc_host_model
(
    // Device side of the link
    input wire logic link_clk,
    input wire logic link_busy,
    input wire logic [7:0] link_rdata,
    // Request lines
    output logic link_sel,
    output logic link_write,
    output logic [7:0] link_addr,
    output logic [7:0] link_wdata,
    output logic link_trig_cmd
);
    initial
    begin
        link_sel = 1'b0;
        link_write = 1'b0;
        link_addr = 8'h00;
        link_wdata = 8'h00;
        link_trig_cmd = 1'b0;
    end

    // Callers also pass undefined addresses and reserved field codes
    task automatic xfer(input logic wr, input logic [7:0] a,
        input logic [7:0] d, input logic tc, output logic [7:0] q);
        int n;
        @(posedge link_clk);
        link_sel <= 1'b1;
        link_write <= wr;
        link_addr <= a;
        link_wdata <= d;
        link_trig_cmd <= tc;
        @(posedge link_clk);
        // Released lines, except link_write, must not keep their last value
        link_sel <= 1'b0;
        link_addr <= ~a;
        link_wdata <= ~d;
        link_trig_cmd <= 1'b0;
        n = 0;
        do
        begin
            @(posedge link_clk);
            n++;
        end
        while (link_busy !== 1'b0 && n < 40);
        q = link_rdata;
    endtask
endmodule
`default_nettype wire

// ---- test/hscc_config_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define check_eq(got, exp) \
    begin \
        check_count++; \
        if ((got) !== (exp)) \
        begin \
            fail_count++; \
            $display("BAD at %0t got %0h exp %0h", $time, (got), (exp)); \
        end \
    end
module hscc_config_tb;
    import hscc_pkg::*;
    // Short millisecond keeps wake-sleep gaps affordable
    localparam int unsigned CPM = 1000;
    logic ref_clk, link_clk, rst, int_trig_n, link_busy, conv_start;
    logic link_sel, link_write, link_trig_cmd, conv_active;
    logic noise_power_select, glitch_filter_en, trig_from_pin;
    logic threshold_direction, gain_channel_select;
    logic xy_range_double, z_range_double;
    logic [1:0] operating_mode, angle_pair_select;
    logic [3:0] axis_channel_enable, sleep_interval_select;
    logic [2:0] threshold_style_select, crossings_needed;
    logic [2:0] axis_threshold_enable;
    logic [7:0] link_addr, link_wdata, link_rdata, q;
    logic [7:0] axis_threshold_code_x, axis_threshold_code_y;
    logic [7:0] axis_threshold_code_z;
    int fail_count, check_count, cyc, starts, last_start, gap, s, g0, dg;

    hscc_config #(.CYCLES_PER_MS(CPM)) dut (.ref_clk, .link_clk, .rst,
        .link_sel, .link_write, .link_addr, .link_wdata, .link_trig_cmd,
        .link_rdata, .link_busy, .int_trig_n, .threshold_style_select,
        .noise_power_select, .glitch_filter_en, .trig_from_pin,
        .operating_mode, .axis_channel_enable, .sleep_interval_select,
        .crossings_needed, .threshold_direction, .gain_channel_select,
        .angle_pair_select, .xy_range_double, .z_range_double,
        .axis_threshold_code_x, .axis_threshold_code_y,
        .axis_threshold_code_z, .axis_threshold_enable, .conv_start,
        .conv_active);
    hscc_host_model host (.link_clk, .link_busy, .link_rdata, .link_sel,
        .link_write, .link_addr, .link_wdata, .link_trig_cmd);

    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial
    begin
        link_clk = 1'b0;
        #3.3;
        forever #40 link_clk = ~link_clk;
    end

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Start counter and gap between consecutive starts; hang guard
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (conv_start === 1'b1)
        begin
            starts <= starts + 1;
            last_start <= cyc;
            gap <= cyc - last_start;
        end
        if (cyc == 100000)
        begin
            fail_count++;
            print_verdict();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.xfer(1'b1, a, d, 1'b0, q);
        `check_eq(link_busy, 1'b0);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        host.xfer(1'b0, a, 8'h00, 1'b0, q);
        `check_eq(q, e);
    endtask
    task automatic trig_cmd;
        host.xfer(1'b0, OFS_DEVICE_MODE_CONTROL, 8'h00, 1'b1, q);
        `check_eq(link_busy, 1'b0);
    endtask
    task automatic pin_pulse;
        @(posedge ref_clk);
        int_trig_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        int_trig_n <= 1'b1;
    endtask
    task automatic wait_starts(input int n);
        int t;
        t = starts + n;
        repeat (30000)
        begin
            @(posedge ref_clk);
            if (starts >= t)
                break;
        end
        `check_eq(starts >= t, 1'b1);
    endtask
    task automatic wait_idle;
        repeat (3000)
        begin
            @(posedge ref_clk);
            if (conv_active === 1'b0)
                break;
        end
        `check_eq(conv_active, 1'b0);
    endtask

    initial
    begin
        rst = 1'b1;
        int_trig_n = 1'b1;
        fail_count = 0;
        check_count = 0;
        cyc = 0;
        starts = 0;
        last_start = 0;
        gap = 0;
        repeat (4) @(posedge ref_clk);
        repeat (2) @(posedge link_clk);
        @(posedge ref_clk) rst <= 1'b0;
        for (int i = 1; i <= 3; i++)
            rd_chk(8'(i), REG_RESET);
        `check_eq(glitch_filter_en, 1'b1);
        `check_eq(operating_mode, MODE_STANDBY);
        wr(8'h00, 8'hFF);
        wr(8'h07, 8'hFF);
        rd_chk(8'h00, 8'h00);
        rd_chk(8'h07, 8'h00);
        wr(OFS_DEVICE_MODE_CONTROL, 8'h38);
        rd_chk(OFS_DEVICE_MODE_CONTROL, 8'h38);
        `check_eq(threshold_style_select, STYLE_SYMMETRIC);
        `check_eq(noise_power_select, 1'b1);
        `check_eq(glitch_filter_en, 1'b0);
        wr(OFS_THRESHOLD_ANGLE_RANGE, 8'hFF);
        rd_chk(OFS_THRESHOLD_ANGLE_RANGE, RANGE_WR_MASK);
        `check_eq(crossings_needed, CROSS_FOUR);
        `check_eq(threshold_direction, 1'b1);
        `check_eq(gain_channel_select, 1'b1);
        `check_eq(xy_range_double, 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            wr(OFS_THRESHOLD_ANGLE_RANGE, 8'(i * 4 + i % 2));
            `check_eq(angle_pair_select, 2'(i));
            `check_eq(z_range_double, 1'(i % 2));
            `check_eq(xy_range_double, 1'b0);
        end
        wr(OFS_THRESHOLD_ANGLE_RANGE, 8'h20);
        wr(OFS_DEVICE_MODE_CONTROL, 8'h40);
        `check_eq(threshold_direction, 1'b0);
        wr(OFS_DEVICE_MODE_CONTROL, 8'h00);
        `check_eq(threshold_direction, 1'b1);
        for (int i = 0; i < 12; i++)
        begin
            wr(OFS_CHANNEL_AND_SLEEP, {4'(i), 4'(i)});
            `check_eq(axis_channel_enable, 4'(i));
            `check_eq(sleep_interval_select, 4'(i));
        end
        wr(OFS_THR_X, 8'h80);
        wr(OFS_THR_Y, 8'h00);
        wr(OFS_THR_Z, 8'h01);
        `check_eq(axis_threshold_enable, 3'h5);
        `check_eq(axis_threshold_code_x, 8'h80);
        `check_eq(axis_threshold_code_y, 8'h00);
        `check_eq(axis_threshold_code_z, 8'h01);
        rd_chk(OFS_THR_X, 8'h80);
        // Three command triggers inside one conversion give two starts
        s = starts;
        trig_cmd();
        trig_cmd();
        trig_cmd();
        repeat (5000) @(posedge ref_clk);
        `check_eq(starts - s, 2);
        wr(OFS_DEVICE_MODE_CONTROL, 8'h04);
        `check_eq(trig_from_pin, 1'b1);
        s = starts;
        trig_cmd();
        repeat (300) @(posedge ref_clk);
        `check_eq(starts - s, 0);
        pin_pulse();
        repeat (300) @(posedge ref_clk);
        `check_eq(starts - s, 1);
        wait_idle();
        wr(OFS_DEVICE_MODE_CONTROL, 8'h05);
        s = starts;
        pin_pulse();
        wr(OFS_DEVICE_MODE_CONTROL, 8'h01);
        trig_cmd();
        repeat (300) @(posedge ref_clk);
        `check_eq(starts - s, 0);
        wr(OFS_DEVICE_MODE_CONTROL, 8'h02);
        s = starts;
        repeat (4500) @(posedge ref_clk);
        `check_eq(starts - s >= 2, 1'b1);
        `check_eq(conv_active, 1'b1);
        wr(OFS_DEVICE_MODE_CONTROL, 8'h00);
        wait_idle();
        wr(OFS_CHANNEL_AND_SLEEP, 8'h00);
        wr(OFS_DEVICE_MODE_CONTROL, 8'h03);
        wait_starts(3);
        g0 = gap;
        wr(OFS_CHANNEL_AND_SLEEP, 8'h01);
        wait_starts(2);
        dg = int'((SLEEP_MS[1] - SLEEP_MS[0]) * CPM);
        `check_eq(gap - g0, dg);
        wr(OFS_CHANNEL_AND_SLEEP, 8'h00);
        wait_starts(2);
        wait_idle();
        pin_pulse();
        repeat (20) @(posedge ref_clk);
        rd_chk(OFS_DEVICE_MODE_CONTROL, 8'h00);
        `check_eq(operating_mode, MODE_STANDBY);
        s = starts;
        repeat (3000) @(posedge ref_clk);
        `check_eq(starts - s, 0);
        print_verdict();
    end
endmodule
`default_nettype wire
